// *** include/ppsc_pkg.sv ***
package ppsc_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_CORES = 4;
  localparam int NUM_THREADS = 2;
  localparam int LLC_WAYS = 16;
  localparam int WAY_W = 5;
  localparam logic [WAY_W-1:0] WAY_LAST = 5'h0F;
  localparam logic [WAY_W-1:0] WAY_INC = 5'h01;
  localparam logic [WAY_W-1:0] WAY_ZERO = 5'h00;

  // ------------------------------------------------------------
  // idle states, numeric order is depth order
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CS_C0 = 4'h0,
    CS_C1 = 4'h1,
    CS_C1E = 4'h2,
    CS_C2 = 4'h3,
    CS_C3 = 4'h4,
    CS_C6 = 4'h5,
    CS_C7 = 4'h6,
    CS_C8 = 4'h7,
    CS_C9 = 4'h8,
    CS_C10 = 4'h9
  } ppsc_cstate_t;

  // ------------------------------------------------------------
  // system sleep request codes
  // ------------------------------------------------------------
  localparam logic [2:0] SLP_S0 = 3'h0;
  localparam logic [2:0] SLP_S3_COLD = 3'h1;
  localparam logic [2:0] SLP_S3_HOT = 3'h2;
  localparam logic [2:0] SLP_S4 = 3'h3;
  localparam logic [2:0] SLP_S5 = 3'h4;

  // ------------------------------------------------------------
  // regulator modes
  // ------------------------------------------------------------
  localparam logic [1:0] REG_NORMAL = 2'h0;
  localparam logic [1:0] REG_DEEP = 2'h1;
  localparam logic [1:0] REG_LPM = 2'h2;

  // ------------------------------------------------------------
  // state machines
  // ------------------------------------------------------------
  typedef enum logic [1:0] {LK_L0 = 2'h0, LK_L1 = 2'h1, LK_L3 = 2'h3} ppsc_link_t;
  typedef enum logic [3:0] {CQ_RUN = 4'h1, CQ_FLUSH = 4'h2, CQ_SAVE = 4'h4, CQ_IDLE = 4'h8} ppsc_cseq_t;
  typedef enum logic [4:0] {
    MS_UP = 5'h01,
    MS_CLOSE = 5'h02,
    MS_PPD = 5'h04,
    MS_APD = 5'h08,
    MS_SR = 5'h10
  } ppsc_mem_t;
  typedef enum logic [2:0] {SY_ON = 3'h1, SY_S3 = 3'h2, SY_OFF = 3'h4} ppsc_sys_t;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic halt;
    logic lowFreq;
    logic flushReq;
    logic clkStop;
    logic saveReq;
    logic pwrOff;
  } ppsc_core_ctl_t;

  typedef struct packed {
    logic flushDone;
    logic saveDone;
  } ppsc_core_ack_t;

  typedef struct packed {
    logic cke;
    logic closeBanks;
    logic selfRefresh;
  } ppsc_mem_ctl_t;

  typedef struct packed {
    logic refClkStop;
    logic clk24Stop;
    logic llcPwrOff;
    logic coreDomOff;
    logic gfxDomOff;
    logic saDomOff;
    logic ioRailOn;
    logic procPwrOff;
    logic [1:0] regMode;
  } ppsc_pkg_ctl_t;

endpackage

// *** rtl/ppsc_core_seq.sv ***
`timescale 1ns/1ps
module ppsc_core_seq
(
  // clock and reset
  input logic clk,
  input logic rst,
  // thread requests
  input ppsc_pkg::ppsc_cstate_t [ppsc_pkg::NUM_THREADS-1:0] threadReq,
  // core handshake
  input ppsc_pkg::ppsc_core_ack_t ack,
  output ppsc_pkg::ppsc_core_ctl_t ctl,
  output ppsc_pkg::ppsc_cstate_t coreState
);
  import ppsc_pkg::*;

  ppsc_cstate_t target;
  ppsc_cseq_t seq_r;
  ppsc_cstate_t coreState_r;

  // ------------------------------------------------------------
  // resolution
  // ------------------------------------------------------------
  always_comb
  begin
    target = threadReq[0];
    for (int t = 1; t < NUM_THREADS; t++)
    begin
      if (threadReq[t] < target)
      begin
        target = threadReq[t];
      end
    end
    // a core has no c2 of its own
    if (target == CS_C2)
    begin
      target = CS_C3;
    end
  end

  // ------------------------------------------------------------
  // entry and exit sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_r <= CQ_RUN;
      coreState_r <= CS_C0;
    end
    else
    begin
      unique case (seq_r)
        CQ_RUN:
        begin
          if (target == CS_C1 || target == CS_C1E)
          begin
            coreState_r <= target;
            seq_r <= CQ_IDLE;
          end
          else if (target >= CS_C3)
          begin
            seq_r <= CQ_FLUSH;
          end
        end
        CQ_FLUSH:
        begin
          if (target < CS_C3)
          begin
            seq_r <= CQ_RUN;
          end
          else if (ack.flushDone)
          begin
            seq_r <= (target >= CS_C6) ? CQ_SAVE : CQ_IDLE;
            coreState_r <= (target >= CS_C6) ? CS_C0 : CS_C3;
          end
        end
        CQ_SAVE:
        begin
          if (target < CS_C6)
          begin
            seq_r <= CQ_RUN;
          end
          else if (ack.saveDone)
          begin
            seq_r <= CQ_IDLE;
            coreState_r <= target;
          end
        end
        CQ_IDLE:
        begin
          if (target != coreState_r)
          begin
            seq_r <= CQ_RUN;
            coreState_r <= CS_C0;
          end
        end
        default:
        begin
          seq_r <= CQ_RUN;
          coreState_r <= CS_C0;
        end
      endcase
    end
  end

  always_comb
  begin
    ctl.halt = (seq_r == CQ_IDLE) && (coreState_r == CS_C1 || coreState_r == CS_C1E);
    ctl.lowFreq = (seq_r == CQ_IDLE) && (coreState_r == CS_C1E);
    ctl.flushReq = (seq_r == CQ_FLUSH);
    ctl.clkStop = (seq_r == CQ_IDLE) && (coreState_r >= CS_C3);
    ctl.saveReq = (seq_r == CQ_SAVE);
    ctl.pwrOff = (seq_r == CQ_IDLE) && (coreState_r >= CS_C6);
  end

  assign coreState = coreState_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_core_via_c0: assert property (@(posedge clk) disable iff (rst)
    ($past(coreState_r) != CS_C0 && coreState_r != $past(coreState_r)) |-> coreState_r == CS_C0)
    else $error("core left an idle state without passing c0");
  a_thread_active: assert property (@(posedge clk) disable iff (rst)
    (threadReq[0] == CS_C0 || threadReq[1] == CS_C0) |=> coreState_r == CS_C0)
    else $error("active thread did not hold core in c0");
  a_pwroff_saved: assert property (@(posedge clk) disable iff (rst)
    $rose(ctl.pwrOff) |-> $past(ack.saveDone) && $past(seq_r) == CQ_SAVE)
    else $error("core voltage removed before state save");

endmodule

// *** rtl/ppsc_mem_pwr.sv ***
`timescale 1ns/1ps
module ppsc_mem_pwr
(
  // clock and reset
  input logic clk,
  input logic rst,
  // requests
  input logic srReq,
  input logic pdReq,
  input logic prefPrecharge,
  input logic anyBankOpen,
  input logic banksClosed,
  // memory side
  output ppsc_pkg::ppsc_mem_ctl_t memCtl,
  output ppsc_pkg::ppsc_mem_t memState
);
  import ppsc_pkg::*;

  ppsc_mem_t state_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= MS_UP;
    end
    else
    begin
      unique case (state_r)
        MS_UP:
        begin
          if (srReq)
          begin
            state_r <= MS_SR;
          end
          else if (pdReq && anyBankOpen && !prefPrecharge)
          begin
            state_r <= MS_APD;
          end
          else if (pdReq)
          begin
            state_r <= anyBankOpen ? MS_CLOSE : MS_PPD;
          end
        end
        MS_CLOSE:
        begin
          if (srReq)
          begin
            state_r <= MS_SR;
          end
          else if (!pdReq)
          begin
            state_r <= MS_UP;
          end
          else if (banksClosed)
          begin
            state_r <= MS_PPD;
          end
        end
        MS_PPD, MS_APD:
        begin
          if (srReq)
          begin
            state_r <= MS_SR;
          end
          else if (!pdReq)
          begin
            state_r <= MS_UP;
          end
        end
        MS_SR:
        begin
          if (!srReq)
          begin
            state_r <= MS_UP;
          end
        end
        default:
        begin
          state_r <= MS_UP;
        end
      endcase
    end
  end

  // cke stays high while banks close; only the final states drop it
  assign memCtl.cke = (state_r == MS_UP) || (state_r == MS_CLOSE);
  assign memCtl.closeBanks = (state_r == MS_CLOSE);
  assign memCtl.selfRefresh = (state_r == MS_SR);
  assign memState = state_r;

  a_ppd_closed: assert property (@(posedge clk) disable iff (rst)
    (state_r == MS_PPD && $past(state_r) != MS_PPD) |-> $past(banksClosed) || !$past(anyBankOpen))
    else $error("precharge power-down entered with banks open");
  a_apd_entry: assert property (@(posedge clk) disable iff (rst)
    (state_r == MS_UP && !srReq && pdReq && anyBankOpen && !prefPrecharge) |=> !memCtl.cke && !memCtl.selfRefresh)
    else $error("active power-down did not drop cke");
  a_sr_entry: assert property (@(posedge clk) disable iff (rst)
    (srReq && state_r != MS_SR) |=> memCtl.selfRefresh && !memCtl.cke)
    else $error("self-refresh not entered within one cycle");

endmodule

// *** rtl/ppsc_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - core c1 halts the core while the package stays in c0.
// - core c1e halts and drops to lowest frequency; package stays c0.
// - package c2 only when all cores c3 or deeper; memory open; transitional.
// - entering c3 cores flush private caches, then stop their clocks.
// - c6 saves core state before voltage removal; reference clock stopped.
// - all cores in c7 lets shared cache ways flush; else like c6.
// - fully flushed shared cache has its voltage removed.
// - package c8 adds c7 actions and needs a fully flushed cache.
// - c9 takes core, graphics and agent domains to 0V; io stays on.
// - c10 puts regulators in deep or low-power mode, stops 24 MHz clock.
// - memory power-up state keeps cke asserted.
// - precharge power-down closes all banks, then drops cke without self-refresh.
// - active power-down drops cke with a bank still open.
// - self-refresh drops cke using the memory's own self-refresh.
// - hub link has l0 active, l1 power-managed and l3 off.
// - only cold suspend-to-memory is supported; hot variant refused.
// - soft-off removes processor power; only reset leaves it.
// - core state is the lowest state its threads request, with c2 taken as c3.
// - core idle states change only by passing through c0.
module ppsc_top
(
  // clock and reset
  input logic clk,
  input logic rst,
  // thread requests
  input ppsc_pkg::ppsc_cstate_t [ppsc_pkg::NUM_CORES-1:0][ppsc_pkg::NUM_THREADS-1:0] threadReq,
  // compute cores
  input ppsc_pkg::ppsc_core_ack_t [ppsc_pkg::NUM_CORES-1:0] coreAck,
  output ppsc_pkg::ppsc_core_ctl_t [ppsc_pkg::NUM_CORES-1:0] coreCtl,
  output ppsc_pkg::ppsc_cstate_t [ppsc_pkg::NUM_CORES-1:0] coreState,
  // shared cache
  input logic llcWayDone,
  output logic llcWayFlushReq,
  // memory controller
  input logic memPdReq,
  input logic memPrefPrecharge,
  input logic memAnyBankOpen,
  input logic memBanksClosed,
  output ppsc_pkg::ppsc_mem_ctl_t memCtl,
  output ppsc_pkg::ppsc_mem_t memState,
  // chip to hub link
  input logic linkBusy,
  output ppsc_pkg::ppsc_link_t linkState,
  // system sleep
  input logic [2:0] sleepReq,
  input logic wakeEvent,
  output logic sleepRefused,
  output logic rebootRequired,
  // power and clocks
  input logic prefRegLowPower,
  output ppsc_pkg::ppsc_pkg_ctl_t pkgCtl,
  output ppsc_pkg::ppsc_cstate_t pkgState
);
  import ppsc_pkg::*;

  ppsc_cstate_t minCore;
  logic allC3;
  logic allC7;
  logic sysOn;
  logic srReq;
  ppsc_cstate_t pkgState_r;
  ppsc_cstate_t pkgNxt;
  logic [WAY_W-1:0] wayCnt_r;
  logic llcEmpty_r;
  ppsc_sys_t sys_r;
  logic sleepRefused_r;
  ppsc_link_t linkState_r;
  ppsc_pkg_ctl_t pkgCtl_r;
  ppsc_pkg_ctl_t pkgCtlNxt;

  // ------------------------------------------------------------
  // per core sequencing
  // ------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CORES; gc++)
    begin : g_core
      ppsc_core_seq u_core
      (
        .clk(clk),
        .rst(rst),
        .threadReq(threadReq[gc]),
        .ack(coreAck[gc]),
        .ctl(coreCtl[gc]),
        .coreState(coreState[gc])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // package resolution
  // ------------------------------------------------------------
  always_comb
  begin
    minCore = coreState[0];
    for (int c = 1; c < NUM_CORES; c++)
    begin
      if (coreState[c] < minCore)
      begin
        minCore = coreState[c];
      end
    end
  end

  assign allC3 = (minCore >= CS_C3);
  assign allC7 = (minCore >= CS_C7);
  assign sysOn = (sys_r == SY_ON);

  always_comb
  begin
    if (!allC3)
    begin
      pkgNxt = CS_C0;
    end
    else if (pkgState_r == CS_C0)
    begin
      pkgNxt = CS_C2;
    end
    else if (minCore >= CS_C8 && !llcEmpty_r)
    begin
      pkgNxt = CS_C7;
    end
    else
    begin
      pkgNxt = minCore;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pkgState_r <= CS_C0;
    end
    else
    begin
      pkgState_r <= pkgNxt;
    end
  end

  assign pkgState = pkgState_r;

  // ------------------------------------------------------------
  // shared cache way flushing
  // ------------------------------------------------------------
  // flushing stops as soon as any core backs out of c7, and the count clears once the package falls to c0
  assign llcWayFlushReq = (pkgState_r >= CS_C7) && allC7 && !llcEmpty_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wayCnt_r <= WAY_ZERO;
      llcEmpty_r <= 1'b0;
    end
    else if (pkgState_r == CS_C0)
    begin
      wayCnt_r <= WAY_ZERO;
      llcEmpty_r <= 1'b0;
    end
    else if (llcWayFlushReq && llcWayDone)
    begin
      wayCnt_r <= wayCnt_r + WAY_INC;
      if (wayCnt_r == WAY_LAST)
      begin
        llcEmpty_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // system sleep
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sys_r <= SY_ON;
    end
    else
    begin
      unique case (sys_r)
        SY_ON:
        begin
          if (sleepReq == SLP_S3_COLD)
          begin
            sys_r <= SY_S3;
          end
          else if (sleepReq == SLP_S4 || sleepReq == SLP_S5)
          begin
            sys_r <= SY_OFF;
          end
        end
        SY_S3:
        begin
          if (wakeEvent)
          begin
            sys_r <= SY_ON;
          end
        end
        SY_OFF:
        begin
          sys_r <= SY_OFF;
        end
        default:
        begin
          sys_r <= SY_ON;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sleepRefused_r <= 1'b0;
    end
    else
    begin
      sleepRefused_r <= sysOn && (sleepReq == SLP_S3_HOT);
    end
  end

  assign sleepRefused = sleepRefused_r;
  assign rebootRequired = (sys_r == SY_OFF);

  // ------------------------------------------------------------
  // memory power
  // ------------------------------------------------------------
  // c2 keeps the memory path open, so self-refresh waits for c3
  assign srReq = (sysOn && pkgState_r >= CS_C3) || (sys_r == SY_S3);

  ppsc_mem_pwr u_mem
  (
    .clk(clk),
    .rst(rst),
    .srReq(srReq),
    .pdReq(memPdReq),
    .prefPrecharge(memPrefPrecharge),
    .anyBankOpen(memAnyBankOpen),
    .banksClosed(memBanksClosed),
    .memCtl(memCtl),
    .memState(memState)
  );

  // ------------------------------------------------------------
  // hub link
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      linkState_r <= LK_L0;
    end
    else if (!sysOn)
    begin
      linkState_r <= LK_L3;
    end
    else if (pkgState_r >= CS_C3 && !linkBusy)
    begin
      linkState_r <= LK_L1;
    end
    else
    begin
      linkState_r <= LK_L0;
    end
  end

  assign linkState = linkState_r;

  // ------------------------------------------------------------
  // package power actions
  // ------------------------------------------------------------
  always_comb
  begin
    pkgCtlNxt.refClkStop = !sysOn || pkgState_r >= CS_C6;
    pkgCtlNxt.llcPwrOff = !sysOn || (pkgState_r >= CS_C7 && llcEmpty_r);
    pkgCtlNxt.coreDomOff = !sysOn || pkgState_r >= CS_C9;
    pkgCtlNxt.gfxDomOff = !sysOn || pkgState_r >= CS_C9;
    pkgCtlNxt.saDomOff = !sysOn || pkgState_r >= CS_C9;
    pkgCtlNxt.ioRailOn = sysOn;
    pkgCtlNxt.procPwrOff = !sysOn;
    pkgCtlNxt.clk24Stop = sysOn && pkgState_r == CS_C10;
    pkgCtlNxt.regMode = REG_NORMAL;
    if (!sysOn || pkgState_r == CS_C10)
    begin
      pkgCtlNxt.regMode = prefRegLowPower ? REG_LPM : REG_DEEP;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pkgCtl_r <= '{ioRailOn: 1'b1, regMode: REG_NORMAL, default: 1'b0};
    end
    else
    begin
      pkgCtl_r <= pkgCtlNxt;
    end
  end

  assign pkgCtl = pkgCtl_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_shallow_pkg_c0: assert property (@(posedge clk) disable iff (rst)
    !allC3 |=> pkgState_r == CS_C0)
    else $error("package left c0 while a core was shallow");
  a_c1e_lowfreq: assert property (@(posedge clk) disable iff (rst)
    (coreState[0] == CS_C1E) |-> coreCtl[0].halt && coreCtl[0].lowFreq && pkgState_r == CS_C0)
    else $error("c1e core not halted at low point");
  a_c2_before_deep: assert property (@(posedge clk) disable iff (rst)
    ($past(pkgState_r) < CS_C2 && pkgState_r >= CS_C2) |-> pkgState_r == CS_C2 && $past(allC3))
    else $error("package skipped c2 on the way down");
  a_c2_mem_open: assert property (@(posedge clk) disable iff (rst)
    (sysOn && pkgState_r == CS_C2) |=> !memCtl.selfRefresh)
    else $error("memory path closed in c2");
  a_flush_first: assert property (@(posedge clk) disable iff (rst)
    $rose(coreCtl[0].clkStop) |-> $past(coreAck[0].flushDone) || $past(coreAck[0].saveDone))
    else $error("core clock stopped before cache flush");
  a_bclk_off: assert property (@(posedge clk) disable iff (rst)
    (pkgState_r >= CS_C6) |=> pkgCtl.refClkStop)
    else $error("reference clock running in c6");
  a_way_flush: assert property (@(posedge clk) disable iff (rst)
    llcWayFlushReq |-> allC7 && pkgState_r >= CS_C7)
    else $error("cache ways flushed without all cores in c7");
  a_llc_rail: assert property (@(posedge clk) disable iff (rst)
    (sysOn && pkgState_r >= CS_C7 && llcEmpty_r) |=> pkgCtl.llcPwrOff)
    else $error("flushed cache kept its voltage");
  a_c8_flushed: assert property (@(posedge clk) disable iff (rst)
    (pkgState_r >= CS_C8) |-> llcEmpty_r && wayCnt_r == WAY_ZERO + 5'h10)
    else $error("c8 reached with cache not flushed");
  a_c9_rails: assert property (@(posedge clk) disable iff (rst)
    (sysOn && pkgState_r >= CS_C9) |=> pkgCtl.coreDomOff && pkgCtl.gfxDomOff && pkgCtl.saDomOff && pkgCtl.ioRailOn)
    else $error("c9 rails wrong");
  a_c10_regs: assert property (@(posedge clk) disable iff (rst)
    (sysOn && pkgState_r == CS_C10) |=> pkgCtl.regMode != REG_NORMAL && pkgCtl.clk24Stop)
    else $error("c10 regulators or 24 MHz clock not lowered");
  a_link_sleep: assert property (@(posedge clk) disable iff (rst)
    !sysOn |=> linkState == LK_L3)
    else $error("link not off in sleep");
  a_hot_s3: assert property (@(posedge clk) disable iff (rst)
    (sysOn && sleepReq == SLP_S3_HOT) |=> sys_r == SY_ON && sleepRefused)
    else $error("hot suspend was accepted");
  a_soft_off: assert property (@(posedge clk) disable iff (rst)
    (sys_r == SY_OFF) |=> sys_r == SY_OFF && pkgCtl.procPwrOff && rebootRequired)
    else $error("soft-off left without reset");
  a_pkg_code: assert property (@(posedge clk) disable iff (rst)
    pkgState != CS_C1 && pkgState != CS_C1E && pkgState <= $past(minCore))
    else $error("package state output stale");

  c_reach_c10: cover property (@(posedge clk) disable iff (rst) pkgState_r == CS_C10);
  c_llc_empty: cover property (@(posedge clk) disable iff (rst) $rose(llcEmpty_r));
  c_s3_wake: cover property (@(posedge clk) disable iff (rst) sys_r == SY_S3 ##1 sys_r == SY_ON);
  c_link_l1: cover property (@(posedge clk) disable iff (rst) linkState == LK_L1);

endmodule

// *** testbench/package_power_state_control_tb_top.sv ***
`timescale 1ns/1ps
module package_power_state_control_tb_top;
  import ppsc_pkg::*;
  logic clk, rst, slow, lwd, lwr, pd, pp, bo, bc, lb, wk, sr, rr, pr;
  logic [2:0] sq;
  logic [31:0] seed;
  int error_cnt, n_compared, a, b;
  ppsc_cstate_t [NUM_CORES-1:0][NUM_THREADS-1:0] tr;
  ppsc_core_ack_t [NUM_CORES-1:0] ack;
  ppsc_core_ctl_t [NUM_CORES-1:0] cc;
  ppsc_cstate_t [NUM_CORES-1:0] cs;
  ppsc_cstate_t ps, prevC;
  ppsc_mem_ctl_t mc;
  ppsc_mem_t ms;
  ppsc_link_t ls;
  ppsc_pkg_ctl_t pc, ex;
  ppsc_top ppsc_top_i (.clk(clk), .rst(rst), .threadReq(tr), .coreAck(ack), .coreCtl(cc),
    .coreState(cs), .llcWayDone(lwd), .llcWayFlushReq(lwr), .memPdReq(pd), .memPrefPrecharge(pp),
    .memAnyBankOpen(bo), .memBanksClosed(bc), .memCtl(mc), .memState(ms), .linkBusy(lb),
    .linkState(ls), .sleepReq(sq), .wakeEvent(wk), .sleepRefused(sr), .rebootRequired(rr),
    .prefRegLowPower(pr), .pkgCtl(pc), .pkgState(ps));
  ppsc_far_model ppsc_far_model_i (.clk(clk), .rst(rst), .slow(slow), .coreCtl(cc),
    .llcWayFlushReq(lwr), .memCtl(mc), .coreAck(ack), .llcWayDone(lwd), .memBanksClosed(bc));
  // ------
  // helpers
  // ------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setAll(ppsc_cstate_t v);
    for (int c = 0; c < NUM_CORES; c++)
    begin
      tr[c][0] = v;
      tr[c][1] = v;
    end
  endtask
  task automatic waitPkg(ppsc_cstate_t s);
    int k = 0;
    while (ps !== s && k < 400)
    begin
      step(1);
      k++;
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ------
  // clock, watchdog, monitor
  // ------
  initial
  begin
    clk = 0;
    forever #5 clk = !clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  // a core never hops between two idle states directly
  always @(posedge clk)
  begin
    if (!rst && prevC !== CS_C0 && cs[0] !== CS_C0)
      chk("hop", cs[0], prevC);
    prevC <= cs[0];
  end
  // ------
  // main sequence
  // ------
  initial
  begin
    {rst, slow, pd, pp, bo, lb, wk} = 7'h40;
    sq = SLP_S0;
    seed = 71130;
    pr = 0;
    setAll(CS_C0);
    step(10);
    rst = 0;
    step(1);
    chk("pkg", ps, CS_C0);
    chk("cke", mc.cke, 1);
    chk("link", ls, LK_L0);
    repeat (12)
    begin
      a = xs() % 3;
      b = xs() % 3;
      tr[0][1] = ppsc_cstate_t'(a);
      tr[0][0] = ppsc_cstate_t'(b);
      step(4);
      a = a < b ? a : b;
      chk("core", cs[0], a);
      chk("halt", cc[0].halt, a != 0);
      chk("lowf", cc[0].lowFreq, a == 2);
      chk("pkg", ps, CS_C0);
    end
    pr = 1'(xs() & 1);
    slow = 1;
    setAll(CS_C10);
    waitPkg(CS_C2);
    chk("cke", mc.cke, 1);
    step(1);
    chk("pkg", ps, CS_C7);
    chk("wayq", lwr, 1);
    chk("llcoff", pc.llcPwrOff, 0);
    waitPkg(CS_C10);
    step(3);
    ex = '{1, 1, 1, 1, 1, 1, 1, 0, pr ? REG_LPM : REG_DEEP};
    chk("pkgctl", pc, ex);
    chk("pwr", {cc[1].clkStop, cc[1].pwrOff}, 3);
    chk("mem", ms, MS_SR);
    chk("link", ls, LK_L1);
    lb = 1;
    step(2);
    chk("link", ls, LK_L0);
    setAll(CS_C0);
    waitPkg(CS_C0);
    step(2);
    chk("mem", ms, MS_UP);
    {pd, pp, bo} = 3'h7;
    step(1);
    chk("close", {ms, mc}, {MS_CLOSE, 3'h6});
    step(4);
    chk("ppd", {ms, mc}, {MS_PPD, 3'h0});
    pd = 0;
    step(3);
    {pd, pp} = 2'h2;
    step(3);
    chk("apd", {ms, mc}, {MS_APD, 3'h0});
    pd = 0;
    sq = SLP_S3_HOT;
    step(2);
    chk("refuse", sr, 1);
    sq = SLP_S3_COLD;
    step(3);
    chk("s3", {ms, ls}, {MS_SR, LK_L3});
    sq = SLP_S0;
    wk = 1;
    step(4);
    wk = 0;
    chk("wake", ms, MS_UP);
    sq = SLP_S5;
    step(3);
    wk = 1;
    step(3);
    chk("off", {rr, pc.procPwrOff}, 3);
    // only a reset brings the package back from soft-off
    rst = 1;
    sq = SLP_S0;
    wk = 0;
    step(2);
    rst = 0;
    step(1);
    chk("boot", {rr, pc.procPwrOff, pc.ioRailOn, ls}, 5'h04);
    sq = SLP_S4;
    step(3);
    chk("s4", {rr, pc.procPwrOff}, 3);
    summarize();
  end
endmodule

// *** testbench/ppsc_far_model.sv ***
`timescale 1ns/1ps
module ppsc_far_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  // design side
  input ppsc_pkg::ppsc_core_ctl_t [ppsc_pkg::NUM_CORES-1:0] coreCtl,
  input wire logic llcWayFlushReq,
  input ppsc_pkg::ppsc_mem_ctl_t memCtl,
  // answers
  output ppsc_pkg::ppsc_core_ack_t [ppsc_pkg::NUM_CORES-1:0] coreAck,
  output logic llcWayDone,
  output logic memBanksClosed
);
  import ppsc_pkg::*;
  logic tick;
  logic ok;
  // slow mode answers only every other cycle
  assign ok = !slow | tick;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick <= 1'b0;
      coreAck <= '0;
      llcWayDone <= 1'b0;
      memBanksClosed <= 1'b0;
    end
    else
    begin
      tick <= !tick;
      for (int c = 0; c < NUM_CORES; c++)
      begin
        coreAck[c].flushDone <= coreCtl[c].flushReq & ok;
        coreAck[c].saveDone <= coreCtl[c].saveReq & ok;
      end
      llcWayDone <= llcWayFlushReq & ok;
      memBanksClosed <= memCtl.closeBanks & ok;
    end
  end
endmodule
